// file: src/acmp_ctrl.sv
// dual comparator digital control: registers, output path, timer gate, pin route, interrupt
`timescale 1ns/1ns
`default_nettype none
`include "acmp_defs.svh"
module acmp_ctrl #(
    parameter int NUM_CMP = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire acmp_pkg::acmp_addr_t reg_addr,
    input wire acmp_pkg::acmp_byte_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output acmp_pkg::acmp_byte_t reg_rdata,
    // analog front end: raw compare results in, controls out
    input wire logic [1:0] cmp_raw,
    output logic [1:0] cmp_enable,
    output logic [1:0] cmp_hysteresis_enable,
    output acmp_pkg::acmp_sel_t noninv_input_select0,
    output acmp_pkg::acmp_sel_t inv_input_select0,
    output acmp_pkg::acmp_sel_t noninv_input_select1,
    output acmp_pkg::acmp_sel_t inv_input_select1,
    // timer source clock, sampled
    input wire logic timer_src_clk,
    // timer gate source
    output logic timer_gate,
    // pin route
    input wire logic pin_direction_control,
    output logic pin_out,
    output logic pin_oe,
    // interrupt
    output logic irq
);
    import acmp_pkg::*;

    acmp_byte_t main_reg [2];
    acmp_byte_t cfg_reg [2];
    acmp_byte_t route_reg;
    logic [1:0] irq_mask;
    logic [1:0] irq_status;
    logic [1:0] result;
    logic [1:0] result_unlatched;
    logic [1:0] edge_event;
    logic timer_prev;
    wire logic timer_fall;
    wire logic [1:0] clear_mask;
    wire logic [1:0] pin_sel;
    wire logic next_pin_out;
    wire logic next_pin_oe;
    wire logic next_gate;
    wire logic next_irq;
    acmp_byte_t next_rdata;

    acmp_chan_if chan_bus [2] ();

    function automatic acmp_byte_t acmp_main_read(input acmp_byte_t r, input logic res);
        acmp_byte_t v;
        v = r & `ACMP_MAIN_WMASK;
        v[`ACMP_MAIN_SP_BIT] = 1'b1;
        v[`ACMP_MAIN_OUT_BIT] = res;
        return v;
    endfunction : acmp_main_read

    // timer source clock sampled as a plain input; falling edge found here
    assign timer_fall = timer_prev & ~timer_src_clk;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cmp
            assign chan_bus[gi].enable = main_reg[gi][`ACMP_MAIN_EN_BIT];
            assign chan_bus[gi].invert = main_reg[gi][`ACMP_MAIN_INV_BIT];
            assign chan_bus[gi].sync_enable = main_reg[gi][`ACMP_MAIN_SYNC_BIT];
            assign chan_bus[gi].rise_irq_enable = cfg_reg[gi][`ACMP_CFG_RISE_BIT];
            assign chan_bus[gi].fall_irq_enable = cfg_reg[gi][`ACMP_CFG_FALL_BIT];
            assign chan_bus[gi].raw_in = cmp_raw[gi];
            assign result[gi] = chan_bus[gi].result;
            assign result_unlatched[gi] = chan_bus[gi].result_unlatched;
            assign edge_event[gi] = chan_bus[gi].edge_event;

            acmp_channel u_chan (
                .clk(clk),
                .reset(reset),
                .timer_fall(timer_fall),
                .ch(chan_bus[gi])
            );
        end
    endgenerate

    acmp_edge_flag #(.WIDTH(2)) u_flags (
        .clk(clk),
        .reset(reset),
        .set_pulse(edge_event),
        .clear_mask(clear_mask),
        .flags(irq_status)
    );

    // write-one-to-clear of the status register
    assign clear_mask = (reg_write && reg_addr == `ACMP_REG_IRQ_STATUS) ? reg_wdata[1:0] : 2'h0;

    // software should pick sync when gating the timer; gate itself is a plain mux
    assign next_gate = result[route_reg[`ACMP_ROUTE_GATE_BIT]];
    assign pin_sel = route_reg[`ACMP_ROUTE_PIN_LSB +: 2];
    // pin only driven with a comparator source chosen and direction cleared
    assign next_pin_oe = !pin_direction_control && (pin_sel == ACMP_PIN_CMP0 || pin_sel == ACMP_PIN_CMP1);
    assign next_pin_out = (pin_sel == ACMP_PIN_CMP0) ? result_unlatched[0]
                        : (pin_sel == ACMP_PIN_CMP1) ? result_unlatched[1] : 1'b0;
    assign next_irq = |(irq_status & irq_mask);

    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `ACMP_REG_MAIN0: next_rdata = acmp_main_read(main_reg[0], result[0]);
            `ACMP_REG_CFG0: next_rdata = cfg_reg[0];
            `ACMP_REG_MAIN1: next_rdata = acmp_main_read(main_reg[1], result[1]);
            `ACMP_REG_CFG1: next_rdata = cfg_reg[1];
            `ACMP_REG_SUMMARY: next_rdata = {6'h00, result};
            `ACMP_REG_IRQ_STATUS: next_rdata = {6'h00, irq_status};
            `ACMP_REG_IRQ_MASK: next_rdata = {6'h00, irq_mask};
            `ACMP_REG_ROUTE: next_rdata = route_reg & 8'h07;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            main_reg[0] <= `ACMP_MAIN_RESET;
            main_reg[1] <= `ACMP_MAIN_RESET;
            cfg_reg[0] <= `ACMP_CFG_RESET;
            cfg_reg[1] <= `ACMP_CFG_RESET;
            route_reg <= `ACMP_ROUTE_RESET;
            irq_mask <= 2'h0;
        end else if (reg_write) begin
            unique case (reg_addr)
                `ACMP_REG_MAIN0: main_reg[0] <= (reg_wdata & `ACMP_MAIN_WMASK) | `ACMP_MAIN_RESET;
                `ACMP_REG_CFG0: cfg_reg[0] <= reg_wdata;
                `ACMP_REG_MAIN1: main_reg[1] <= (reg_wdata & `ACMP_MAIN_WMASK) | `ACMP_MAIN_RESET;
                `ACMP_REG_CFG1: cfg_reg[1] <= reg_wdata;
                `ACMP_REG_IRQ_MASK: irq_mask <= reg_wdata[1:0];
                `ACMP_REG_ROUTE: route_reg <= reg_wdata & 8'h07;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            timer_prev <= 1'b0;
            timer_gate <= 1'b0;
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            irq <= 1'b0;
            cmp_enable <= 2'h0;
            cmp_hysteresis_enable <= 2'h0;
            noninv_input_select0 <= 3'h0;
            inv_input_select0 <= 3'h0;
            noninv_input_select1 <= 3'h0;
            inv_input_select1 <= 3'h0;
        end else begin
            reg_rdata <= reg_read ? next_rdata : 8'h00;
            timer_prev <= timer_src_clk;
            timer_gate <= next_gate;
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            irq <= next_irq;
            cmp_enable <= {main_reg[1][`ACMP_MAIN_EN_BIT], main_reg[0][`ACMP_MAIN_EN_BIT]};
            cmp_hysteresis_enable <= {main_reg[1][`ACMP_MAIN_HYS_BIT], main_reg[0][`ACMP_MAIN_HYS_BIT]};
            noninv_input_select0 <= cfg_reg[0][`ACMP_CFG_PSEL_LSB +: 3];
            inv_input_select0 <= cfg_reg[0][`ACMP_CFG_NSEL_LSB +: 3];
            noninv_input_select1 <= cfg_reg[1][`ACMP_CFG_PSEL_LSB +: 3];
            inv_input_select1 <= cfg_reg[1][`ACMP_CFG_NSEL_LSB +: 3];
        end
    end

    a_summary_matches: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_addr == `ACMP_REG_SUMMARY |=> reg_rdata[1:0] == $past(result))
        else $error("summary read differs from result");
    a_pin_needs_dir: assert property (@(posedge clk) disable iff (reset)
        pin_direction_control |=> !pin_oe)
        else $error("pin driven with direction set");
    a_irq_level: assert property (@(posedge clk) disable iff (reset)
        |(irq_status & irq_mask) |=> irq)
        else $error("unmasked flag did not raise interrupt");
    a_enable_out: assert property (@(posedge clk) disable iff (reset)
        reg_write && reg_addr == `ACMP_REG_MAIN0 ##1 1'b1 |=> cmp_enable[0] == $past(reg_wdata[7], 2))
        else $error("enable output does not follow register");
    a_hys_out: assert property (@(posedge clk) disable iff (reset)
        reg_write && reg_addr == `ACMP_REG_MAIN1 ##1 1'b1 |=> cmp_hysteresis_enable[1] == $past(reg_wdata[1], 2))
        else $error("hysteresis output does not follow register");
endmodule : acmp_ctrl
`default_nettype wire

// file: pkg/acmp_defs.svh
// register map, field positions and reset values of the comparator control block
`ifndef ACMP_DEFS_SVH
`define ACMP_DEFS_SVH

// register indexes, one byte each
`define ACMP_REG_MAIN0 4'h0
`define ACMP_REG_CFG0 4'h1
`define ACMP_REG_MAIN1 4'h2
`define ACMP_REG_CFG1 4'h3
`define ACMP_REG_SUMMARY 4'h4
`define ACMP_REG_IRQ_STATUS 4'h5
`define ACMP_REG_IRQ_MASK 4'h6
`define ACMP_REG_ROUTE 4'h7

// main control fields
`define ACMP_MAIN_EN_BIT 7
`define ACMP_MAIN_OUT_BIT 6
`define ACMP_MAIN_INV_BIT 4
`define ACMP_MAIN_SP_BIT 2
`define ACMP_MAIN_HYS_BIT 1
`define ACMP_MAIN_SYNC_BIT 0
`define ACMP_MAIN_WMASK 8'h97
`define ACMP_MAIN_RESET 8'h04

// input and edge config fields
`define ACMP_CFG_RISE_BIT 7
`define ACMP_CFG_FALL_BIT 6
`define ACMP_CFG_PSEL_LSB 3
`define ACMP_CFG_NSEL_LSB 0
`define ACMP_CFG_RESET 8'h00

// route register: gate source select bit 0, pin source select bits 2:1
`define ACMP_ROUTE_GATE_BIT 0
`define ACMP_ROUTE_PIN_LSB 1
`define ACMP_ROUTE_RESET 8'h00

`endif

// file: pkg/acmp_pkg.sv
// types shared by the comparator control block
package acmp_pkg;
    typedef logic [7:0] acmp_byte_t;
    typedef logic [3:0] acmp_addr_t;
    typedef logic [2:0] acmp_sel_t;
    typedef enum logic [1:0] {
        ACMP_PIN_OFF,
        ACMP_PIN_CMP0,
        ACMP_PIN_CMP1,
        ACMP_PIN_LOW
    } acmp_pin_src_t;
endpackage : acmp_pkg

// file: pkg/acmp_chan_if.sv
// per-comparator control and result signals between top and channel
`timescale 1ns/1ns
`default_nettype none
interface acmp_chan_if;
    logic enable;
    logic invert;
    logic sync_enable;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic raw_in;
    logic result;
    logic result_unlatched;
    logic edge_event;
    modport ctrl (output enable, invert, sync_enable, rise_irq_enable, fall_irq_enable, raw_in,
                  input result, result_unlatched, edge_event);
    modport chan (input enable, invert, sync_enable, rise_irq_enable, fall_irq_enable, raw_in,
                  output result, result_unlatched, edge_event);
endinterface : acmp_chan_if
`default_nettype wire

// file: src/acmp_edge_flag.sv
// sticky interrupt status bits with write-one-to-clear where a set wins
`timescale 1ns/1ns
`default_nettype none
module acmp_edge_flag #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // events and clear
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] clear_mask,
    // status
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags;

    // set has priority so an edge during the clearing write is kept
    assign next_flags = (flags & ~clear_mask) | set_pulse;

    always_ff @(posedge clk) begin
        if (reset) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    a_flag_set_wins: assert property (@(posedge clk) disable iff (reset)
        |set_pulse |=> (flags & $past(set_pulse)) == $past(set_pulse))
        else $error("edge event lost against clear");
    a_flag_only_sw_clear: assert property (@(posedge clk) disable iff (reset)
        ((flags & ~clear_mask) != '0) |=> ((flags & $past(flags & ~clear_mask)) == $past(flags & ~clear_mask)))
        else $error("flag dropped without clear");
endmodule : acmp_edge_flag
`default_nettype wire

// file: src/acmp_channel.sv
// one comparator output path: enable gating, cycle latch, timer sync latch, polarity, edge detect
`timescale 1ns/1ns
`default_nettype none
module acmp_channel (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // timer source clock falling edge, one-cycle pulse
    input wire logic timer_fall,
    // control and result
    acmp_chan_if.chan ch
);
    import acmp_pkg::*;

    logic raw_gated;
    logic cycle_latch;
    logic sync_latch;
    logic chosen;
    logic prev_result;
    wire logic next_result;

    // disabled comparator reads low before inversion
    assign raw_gated = ch.enable & ch.raw_in;
    assign chosen = ch.sync_enable ? sync_latch : cycle_latch;
    assign next_result = chosen ^ ch.invert;
    // pin path passes the gated raw value unlatched unless sync is on
    assign ch.result_unlatched = (ch.sync_enable ? sync_latch : raw_gated) ^ ch.invert;
    assign ch.result = next_result;
    assign ch.edge_event = (ch.rise_irq_enable & next_result & ~prev_result)
                         | (ch.fall_irq_enable & ~next_result & prev_result);

    always_ff @(posedge clk) begin
        if (reset) begin
            cycle_latch <= 1'b0;
            sync_latch <= 1'b0;
            prev_result <= 1'b0;
        end else begin
            cycle_latch <= raw_gated;
            if (timer_fall) begin
                sync_latch <= cycle_latch;
            end
            prev_result <= next_result;
        end
    end

    a_chan_cycle_latch: assert property (@(posedge clk) disable iff (reset)
        !ch.sync_enable ##1 !ch.sync_enable |-> ch.result == ($past(raw_gated) ^ ch.invert))
        else $error("latched result does not follow raw input");
    a_chan_disabled_low: assert property (@(posedge clk) disable iff (reset)
        !ch.enable ##1 !ch.enable ##1 !ch.sync_enable |-> ch.result == ch.invert)
        else $error("disabled comparator not at inactive level");
    a_chan_sync_hold: assert property (@(posedge clk) disable iff (reset)
        ch.sync_enable ##1 (ch.sync_enable && !$past(timer_fall) && $stable(ch.invert)) |-> $stable(ch.result))
        else $error("synchronised result moved without timer edge");
endmodule : acmp_channel
`default_nettype wire

// file: bench/acmp_ctrl_bench.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/1ns
`default_nettype none
`include "acmp_defs.svh"
module acmp_ctrl_bench;
    import acmp_pkg::*;
    logic clk;
    logic reset;
    acmp_addr_t reg_addr;
    acmp_byte_t reg_wdata;
    logic reg_write;
    logic reg_read;
    acmp_byte_t reg_rdata;
    logic [1:0] cmp_raw;
    logic [1:0] cmp_enable;
    logic [1:0] cmp_hysteresis_enable;
    acmp_sel_t psel0;
    acmp_sel_t nsel0;
    acmp_sel_t psel1;
    acmp_sel_t nsel1;
    logic timer_src_clk;
    logic timer_gate;
    logic pin_direction_control;
    logic pin_out;
    logic pin_oe;
    logic irq;
    integer seed;
    int n_errors;
    int n_tests;
    acmp_byte_t main_m [2];
    acmp_byte_t rdv;
    acmp_byte_t w;
    logic c;

    acmp_ctrl #(.NUM_CMP(2)) acmp_ctrl_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .cmp_raw(cmp_raw), .cmp_enable(cmp_enable), .cmp_hysteresis_enable(cmp_hysteresis_enable),
        .noninv_input_select0(psel0), .inv_input_select0(nsel0), .noninv_input_select1(psel1),
        .inv_input_select1(nsel1), .timer_src_clk(timer_src_clk), .timer_gate(timer_gate),
        .pin_direction_control(pin_direction_control), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input acmp_byte_t seen, input acmp_byte_t exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input acmp_addr_t a, input acmp_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input acmp_addr_t a, output acmp_byte_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // outputs are looked at 1 ns past the edge, never in the edge's own time step
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic set_raw(input int ch, input logic v);
        @(posedge clk);
        if (ch == 0) cmp_raw[0] <= v;
        else cmp_raw[1] <= v;
        idle(4);
    endtask : set_raw

    task automatic wait_irq();
        for (int i = 0; i < 10 && irq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check(irq, 1'b1);
        if (irq !== 1'b1) tally_and_finish();
    endtask : wait_irq

    function automatic logic res_of(input int ch);
        return (main_m[ch][7] & cmp_raw[ch]) ^ main_m[ch][4];
    endfunction : res_of

    initial begin
        seed = 20;
        n_errors = 0;
        n_tests = 0;
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        cmp_raw = 2'h0;
        timer_src_clk = 1'b1;
        pin_direction_control = 1'b1;
        main_m[0] = `ACMP_MAIN_RESET;
        main_m[1] = `ACMP_MAIN_RESET;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        // reset values, unmapped reads, read-only and w1c writes
        wr(4'hA, 8'hFF);
        wr(`ACMP_REG_SUMMARY, 8'hFF);
        wr(`ACMP_REG_IRQ_STATUS, 8'hFF);
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], rdv);
            check(rdv, (a == 0 || a == 2) ? 8'h04 : 8'h00);
        end
        check({irq, pin_oe, timer_gate}, 8'h00);
        // input and edge config registers, both channels
        for (int k = 0; k < 2; k++) begin
            w = 8'($random(seed));
            wr(k ? `ACMP_REG_CFG1 : `ACMP_REG_CFG0, w);
            idle(2);
            rd(k ? `ACMP_REG_CFG1 : `ACMP_REG_CFG0, rdv);
            check(rdv, w);
            check(k ? {psel1, nsel1} : {psel0, nsel0}, w[5:0]);
        end
        // polarity, enable gating, status views, timer gate and pin route
        for (int i = 0; i < 16; i++) begin
            c = i[3];
            w = 8'($random(seed));
            w[7] = i[2];
            w[4] = i[1];
            w[0] = 1'b0;
            wr(c ? `ACMP_REG_MAIN1 : `ACMP_REG_MAIN0, w);
            main_m[c] = (w & `ACMP_MAIN_WMASK) | `ACMP_MAIN_RESET;
            wr(`ACMP_REG_ROUTE, {5'h00, c ? 2'h2 : 2'h1, c});
            @(posedge clk);
            cmp_raw[c] <= i[0];
            cmp_raw[!c] <= w[6];
            pin_direction_control <= w[5];
            idle(4);
            rd(c ? `ACMP_REG_MAIN1 : `ACMP_REG_MAIN0, rdv);
            check(rdv, main_m[c] | {1'b0, res_of(c), 6'h00});
            rd(`ACMP_REG_SUMMARY, rdv);
            check(rdv, {6'h00, res_of(1), res_of(0)});
            check(timer_gate, res_of(c));
            check(pin_oe, !w[5]);
            if (!w[5]) check(pin_out, res_of(c));
            check({cmp_hysteresis_enable, cmp_enable},
                  {main_m[1][1], main_m[0][1], main_m[1][7], main_m[0][7]});
        end
        // software syncs the gating comparator to the timer clock
        wr(`ACMP_REG_ROUTE, 8'h00);
        wr(`ACMP_REG_MAIN0, 8'h80);
        set_raw(0, 1'b0);
        wr(`ACMP_REG_MAIN0, 8'h81);
        set_raw(0, 1'b1);
        rd(`ACMP_REG_SUMMARY, rdv);
        check(rdv[0], 1'b0);
        check(timer_gate, 1'b0);
        @(posedge clk);
        timer_src_clk <= 1'b0;
        pin_direction_control <= 1'b0;
        idle(4);
        rd(`ACMP_REG_SUMMARY, rdv);
        check(rdv[0], 1'b1);
        check(timer_gate, 1'b1);
        check({pin_oe, pin_out}, 8'h00);
        @(posedge clk);
        timer_src_clk <= 1'b1;
        // pin source low never enables the driver
        wr(`ACMP_REG_ROUTE, 8'h06);
        idle(2);
        check({pin_oe, pin_out}, 8'h00);
        // edge interrupts on comparator 1
        wr(`ACMP_REG_CFG0, 8'h00);
        wr(`ACMP_REG_CFG1, 8'h80);
        wr(`ACMP_REG_MAIN1, 8'h80);
        main_m[1] = 8'h84;
        set_raw(1, 1'b0);
        wr(`ACMP_REG_IRQ_MASK, 8'h02);
        wr(`ACMP_REG_IRQ_STATUS, 8'h03);
        idle(2);
        check(irq, 1'b0);
        set_raw(1, 1'b1);
        wait_irq();
        rd(`ACMP_REG_IRQ_STATUS, rdv);
        check(rdv, 8'h02);
        set_raw(1, 1'b0);
        wr(`ACMP_REG_IRQ_STATUS, 8'h02);
        idle(2);
        rd(`ACMP_REG_IRQ_STATUS, rdv);
        check(rdv, 8'h00);
        check(irq, 1'b0);
        // falling edge only, first masked
        wr(`ACMP_REG_CFG1, 8'h40);
        wr(`ACMP_REG_IRQ_MASK, 8'h00);
        set_raw(1, 1'b1);
        rd(`ACMP_REG_IRQ_STATUS, rdv);
        check(rdv, 8'h00);
        set_raw(1, 1'b0);
        rd(`ACMP_REG_IRQ_STATUS, rdv);
        check(rdv, 8'h02);
        check(irq, 1'b0);
        wr(`ACMP_REG_IRQ_MASK, 8'h02);
        wait_irq();
        // disabled comparator still flags an edge when polarity flips
        wr(`ACMP_REG_CFG1, 8'h80);
        wr(`ACMP_REG_MAIN1, 8'h00);
        idle(3);
        wr(`ACMP_REG_IRQ_STATUS, 8'h03);
        idle(2);
        check(irq, 1'b0);
        wr(`ACMP_REG_MAIN1, 8'h10);
        wait_irq();
        rd(`ACMP_REG_IRQ_STATUS, rdv);
        check(rdv, 8'h02);
        // rising edge lands in the same cycle as the clearing write
        wr(`ACMP_REG_MAIN1, 8'h80);
        wr(`ACMP_REG_IRQ_STATUS, 8'h02);
        cmp_raw[1] <= 1'b1;
        @(posedge clk);
        reg_addr <= `ACMP_REG_IRQ_STATUS;
        reg_wdata <= 8'h02;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        rd(`ACMP_REG_IRQ_STATUS, rdv);
        check(rdv, 8'h02);
        tally_and_finish();
    end
endmodule : acmp_ctrl_bench
`default_nettype wire
